// [common/mcsr_map.vh]
// Register map and field constants for the monitor config/status bank
`ifndef MCSR_MAP_VH
`define MCSR_MAP_VH

`define MCSR_ADDR_FAILSAFE 8'h3d
`define MCSR_ADDR_MAKER 8'h3e
`define MCSR_ADDR_VERSION 8'h3f
`define MCSR_ADDR_CONFIG1 8'h40
`define MCSR_ADDR_STATUS1 8'h41

`define MCSR_RST_FAILSAFE 8'h00
`define MCSR_RST_CONFIG1 8'h84
`define MCSR_RST_STATUS1 8'h00
`define MCSR_FAILSAFE_OFF 8'h80

`define MCSR_CFG_RUN 0
`define MCSR_CFG_LOCK 1
`define MCSR_CFG_READY 2
`define MCSR_CFG_BOOST 3
`define MCSR_CFG_LINK 4
`define MCSR_CFG_OVT 5
`define MCSR_CFG_AVG_HI 7
`define MCSR_CFG_AVG_LO 6

`define MCSR_VER_LINK_CAP 1'b1
`define MCSR_VER_FOURWIRE 1'b1

`define MCSR_DUTY_FULL 8'hff
`define MCSR_UNMAPPED 8'h00
`define MCSR_READY_CYCLES 8'h10
`define MCSR_COUNT_ZERO 8'h00
`define MCSR_COUNT_STEP 8'h01

`define MCSR_RST_RUN 1'b0
`define MCSR_RST_LOCK 1'b0
`define MCSR_RST_BOOST 1'b0
`define MCSR_RST_LINK 1'b0
`define MCSR_RST_OVT 1'b0
`define MCSR_RST_READY 1'b0
`define MCSR_RST_AVG_SEL 2'h2
`define MCSR_RST_FLAGS 7'h00
`define MCSR_RST_RDATA 8'h00
`define MCSR_PIN_IDLE 1'b0
`define MCSR_PIN_MODE_FULL 3'h0

`define MCSR_AVG_SEL_4 2'h0
`define MCSR_AVG_SEL_8 2'h1
`define MCSR_AVG_SEL_16 2'h2
`define MCSR_AVG_CNT_4 6'h04
`define MCSR_AVG_CNT_8 6'h08
`define MCSR_AVG_CNT_16 6'h10
`define MCSR_AVG_CNT_32 6'h20

`endif

// [rtl/mcsr_status_latch.v]
// Sticky limit flags that clear on read only once the fault has gone
`timescale 1ns/100ps
module mcsr_status_latch (
	// Clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// Fault levels and read strobe
	input wire [6:0] fault_i,
	input wire clear_rd_i,
	// Latched flags
	output reg [6:0] flag_o
);
	`include "mcsr_map.vh"

	// Live fault wins over the read clear, so no event is lost
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			flag_o <= `MCSR_RST_FLAGS;
		end else if (clear_rd_i) begin
			flag_o <= fault_i;
		end else begin
			flag_o <= flag_o | fault_i;
		end
	end
endmodule

// [rtl/mcsr_failsafe.v]
// CPU-link temperature fail-safe comparator with hysteresis
`timescale 1ns/100ps
module mcsr_failsafe (
	// Clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// Limit, hysteresis and reading
	input wire [7:0] limit_i,
	input wire [7:0] hyst_i,
	input wire [7:0] temp_i,
	input wire temp_valid_i,
	// Fail-safe state
	output reg active_o
);
	`include "mcsr_map.vh"

	wire [8:0] release_level;
	assign release_level = {1'b0, limit_i} - {1'b0, hyst_i};

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			active_o <= 1'b0;
		end else if (limit_i == `MCSR_FAILSAFE_OFF) begin
			active_o <= 1'b0;
		end else if (temp_valid_i) begin
			if (temp_i > limit_i) begin
				active_o <= 1'b1;
			end else if (release_level[8] || ({1'b0, temp_i} < release_level)) begin
				active_o <= 1'b0;
			end
		end
	end
endmodule

// [rtl/mcsr_regs.v]
// Config/status register bank of the hardware monitor
`timescale 1ns/100ps
module mcsr_regs #(
	parameter [3:0] FAMILY_VERSION = 4'h1, // Arbitrary value
	parameter [1:0] SILICON_REV = 2'h0,    // Arbitrary value
	parameter [7:0] MAKER_CODE = 8'h5a     // Arbitrary value
) (
	// Clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// Register access from the serial slave
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	// Measurement side
	input wire [6:0] limit_fault_i,
	input wire [7:0] status_two_i,
	input wire [7:0] link_temp_i,
	input wire link_temp_valid_i,
	input wire [7:0] failsafe_hyst_i,
	input wire overtemp_pin_i,
	input wire [2:0] overtemp_mode_i,
	input wire [7:0] computed_duty_i,
	input wire [7:0] max_duty_i,
	// Control outputs
	output reg [7:0] pwm_duty_o,
	output wire monitor_run_o,
	output wire use_default_limits_o,
	output wire cpu_link_monitor_enable_o,
	output reg [5:0] average_count_o,
	output wire alert_req_o,
	output wire failsafe_active_o
);
	`include "mcsr_map.vh"

	// Config fields
	reg [7:0] cpu_fan_failsafe_limit;
	reg monitor_run;
	reg lock;
	reg full_speed_force;
	reg cpu_link_monitor_enable;
	reg overtemp_pin_override;
	reg [1:0] average_length_sel;

	// Power-up and pin synchroniser
	reg powerup_done_flag;
	reg [7:0] ready_count;
	reg ovt_sync1;
	reg ovt_sync2;

	// Datapath
	reg [7:0] next_duty;
	reg [7:0] rd_mux;
	wire [6:0] limit_flags;
	wire out_of_limit_summary;
	wire rd_status;
	wire cfg_write;
	wire limit_write;
	wire pin_override_hit;
	wire [7:0] version_word;
	wire [7:0] config_word;
	wire [7:0] status_word;

	function wr_hit;
		input [7:0] a;
		input [7:0] target;
		input we;
		begin
			wr_hit = we && (a == target);
		end
	endfunction

	// A lockable field takes a write only while the bank is unlocked
	function lockable_write;
		input hit;
		input locked;
		begin
			lockable_write = hit && !locked;
		end
	endfunction

	// Readings per averaged value
	function [5:0] avg_readings;
		input [1:0] sel;
		begin
			case (sel)
			`MCSR_AVG_SEL_4: avg_readings = `MCSR_AVG_CNT_4;
			`MCSR_AVG_SEL_8: avg_readings = `MCSR_AVG_CNT_8;
			`MCSR_AVG_SEL_16: avg_readings = `MCSR_AVG_CNT_16;
			default: avg_readings = `MCSR_AVG_CNT_32;
			endcase
		end
	endfunction

	// Duty priority: every full-duty cause ahead of the pin override choice
	function [7:0] duty_pick;
		input run;
		input failsafe;
		input boost;
		input pin_hit;
		input [2:0] mode;
		input [7:0] max_duty;
		input [7:0] computed;
		begin
			if (!run) begin
				duty_pick = `MCSR_DUTY_FULL;
			end else if (failsafe) begin
				duty_pick = `MCSR_DUTY_FULL;
			end else if (boost) begin
				duty_pick = `MCSR_DUTY_FULL;
			end else if (pin_hit && (mode == `MCSR_PIN_MODE_FULL)) begin
				duty_pick = `MCSR_DUTY_FULL;
			end else if (pin_hit) begin
				duty_pick = max_duty;
			end else begin
				duty_pick = computed;
			end
		end
	endfunction

	// Config byte as the host sees it
	function [7:0] pack_config;
		input [1:0] avg_sel;
		input ovt;
		input link;
		input boost;
		input ready;
		input locked;
		input run;
		begin
			pack_config = {avg_sel, ovt, link, boost, ready, locked, run};
		end
	endfunction

	// Read mux over the five registers of this bank
	function [7:0] read_mux;
		input [7:0] a;
		input [7:0] limit;
		input [7:0] version;
		input [7:0] cfg;
		input [7:0] status;
		begin
			case (a)
			`MCSR_ADDR_FAILSAFE: read_mux = limit;
			`MCSR_ADDR_MAKER: read_mux = MAKER_CODE;
			`MCSR_ADDR_VERSION: read_mux = version;
			`MCSR_ADDR_CONFIG1: read_mux = cfg;
			`MCSR_ADDR_STATUS1: read_mux = status;
			default: read_mux = `MCSR_UNMAPPED;
			endcase
		end
	endfunction

	assign rd_status = reg_rd_i && (reg_addr_i == `MCSR_ADDR_STATUS1);
	assign cfg_write = wr_hit(reg_addr_i, `MCSR_ADDR_CONFIG1, reg_wr_i);
	assign limit_write = lockable_write(wr_hit(reg_addr_i, `MCSR_ADDR_FAILSAFE, reg_wr_i), lock);
	assign pin_override_hit = overtemp_pin_override && ovt_sync2;
	assign version_word = {FAMILY_VERSION, `MCSR_VER_FOURWIRE,
		`MCSR_VER_LINK_CAP, SILICON_REV};
	assign config_word = pack_config(average_length_sel, overtemp_pin_override,
		cpu_link_monitor_enable, full_speed_force, powerup_done_flag, lock, monitor_run);
	assign status_word = {out_of_limit_summary, limit_flags};

	mcsr_status_latch u_latch (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.fault_i(limit_fault_i),
		.clear_rd_i(rd_status),
		.flag_o(limit_flags)
	);

	mcsr_failsafe u_failsafe (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.limit_i(cpu_fan_failsafe_limit),
		.hyst_i(failsafe_hyst_i),
		.temp_i(link_temp_i),
		.temp_valid_i(link_temp_valid_i),
		.active_o(failsafe_active_o)
	);

	assign out_of_limit_summary = |status_two_i;
	assign alert_req_o = (|limit_flags) | out_of_limit_summary;
	assign monitor_run_o = monitor_run;
	assign use_default_limits_o = ~monitor_run;
	assign cpu_link_monitor_enable_o = cpu_link_monitor_enable;

	// Overtemp pin is asynchronous to the core clock
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			ovt_sync1 <= `MCSR_PIN_IDLE;
		end else begin
			ovt_sync1 <= overtemp_pin_i;
		end
	end

	// Only the second stage is read by the duty logic
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			ovt_sync2 <= `MCSR_PIN_IDLE;
		end else begin
			ovt_sync2 <= ovt_sync1;
		end
	end

	// Ready comes after a short settle count; a real part waits on its analog bring-up
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			ready_count <= `MCSR_COUNT_ZERO;
		end else if (ready_count != `MCSR_READY_CYCLES) begin
			ready_count <= ready_count + `MCSR_COUNT_STEP;
		end
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			powerup_done_flag <= `MCSR_RST_READY;
		end else if (ready_count == `MCSR_READY_CYCLES) begin
			powerup_done_flag <= 1'b1;
		end
	end

	// Limit is lockable; writes to read-only registers fall through
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			cpu_fan_failsafe_limit <= `MCSR_RST_FAILSAFE;
		end else if (limit_write) begin
			cpu_fan_failsafe_limit <= reg_wdata_i;
		end
	end

	// Run stays writable after lock
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			monitor_run <= `MCSR_RST_RUN;
		end else if (cfg_write) begin
			monitor_run <= reg_wdata_i[`MCSR_CFG_RUN];
		end
	end

	// Boost stays writable after lock
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			full_speed_force <= `MCSR_RST_BOOST;
		end else if (cfg_write) begin
			full_speed_force <= reg_wdata_i[`MCSR_CFG_BOOST];
		end
	end

	// Write-once: a set lock blocks its own rewrite; only reset (power-up) clears it
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			lock <= `MCSR_RST_LOCK;
		end else if (lockable_write(cfg_write, lock)) begin
			lock <= reg_wdata_i[`MCSR_CFG_LOCK];
		end
	end

	// Link monitor enable freezes at lock
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			cpu_link_monitor_enable <= `MCSR_RST_LINK;
		end else if (lockable_write(cfg_write, lock)) begin
			cpu_link_monitor_enable <= reg_wdata_i[`MCSR_CFG_LINK];
		end
	end

	// Pin override freezes at lock
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			overtemp_pin_override <= `MCSR_RST_OVT;
		end else if (lockable_write(cfg_write, lock)) begin
			overtemp_pin_override <= reg_wdata_i[`MCSR_CFG_OVT];
		end
	end

	// Averaging select freezes at lock
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			average_length_sel <= `MCSR_RST_AVG_SEL;
		end else if (lockable_write(cfg_write, lock)) begin
			average_length_sel <= reg_wdata_i[`MCSR_CFG_AVG_HI:`MCSR_CFG_AVG_LO];
		end
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			average_count_o <= avg_readings(`MCSR_RST_AVG_SEL);
		end else begin
			average_count_o <= avg_readings(average_length_sel);
		end
	end

	always @* begin
		next_duty = duty_pick(monitor_run, failsafe_active_o, full_speed_force,
			pin_override_hit, overtemp_mode_i, max_duty_i, computed_duty_i);
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			pwm_duty_o <= `MCSR_DUTY_FULL;
		end else begin
			pwm_duty_o <= next_duty;
		end
	end

	always @* begin
		rd_mux = read_mux(reg_addr_i, cpu_fan_failsafe_limit, version_word,
			config_word, status_word);
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= `MCSR_RST_RDATA;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_mux;
		end
	end
endmodule

// [test/mcsr_properties.sv]
// Port checker for the monitor config/status bank
`timescale 1ns/100ps
module mcsr_props (
	// Clock, reset and bus
	input wire clk_i,
	input wire sys_rst_i,
	input wire [7:0] reg_addr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_rdata_o,
	// Status and control
	input wire [6:0] limit_fault_i,
	input wire [7:0] status_two_i,
	input wire [7:0] pwm_duty_o,
	input wire monitor_run_o,
	input wire use_default_limits_o,
	input wire [5:0] average_count_o,
	input wire alert_req_o,
	input wire failsafe_active_o
);
	wire rd41 = reg_rd_i && reg_addr_i == 8'h41;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_stop_full: assert property (!monitor_run_o && $past(!monitor_run_o)
		|-> pwm_duty_o == 8'hff) else $error("duty not full while stopped");
	a_fs_full: assert property (failsafe_active_o && $past(failsafe_active_o)
		|-> pwm_duty_o == 8'hff) else $error("duty not full in failsafe");
	a_dflt_limits: assert property (use_default_limits_o == !monitor_run_o)
		else $error("default select wrong");
	a_ool_alert: assert property (|status_two_i |-> alert_req_o)
		else $error("alert missing");
	a_ver_bits: assert property (reg_rd_i && reg_addr_i == 8'h3f
		|=> reg_rdata_o[3:2] == 2'b11) else $error("version caps wrong");
	a_ool_read: assert property (rd41 |=> reg_rdata_o[7] == $past(|status_two_i))
		else $error("summary bit wrong");
	a_fault_kept: assert property (rd41 && !$past(sys_rst_i, 2) |=>
		(reg_rdata_o[6:0] & $past(limit_fault_i, 2)) == $past(limit_fault_i, 2))
		else $error("live fault flag lost");
	a_avg_legal: assert property (average_count_o inside {6'd4, 6'd8, 6'd16, 6'd32})
		else $error("averaging count illegal");
	a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved");
endmodule
bind mcsr_regs mcsr_props u_props (.*);

// [test/mcsr_host.sv]
// Host model issuing single-byte register cycles
`timescale 1ns/100ps
module mcsr_host (
	// Clock
	input wire clk_i,
	// Register cycle
	output reg [7:0] addr_o,
	output reg [7:0] wdata_o,
	output reg wr_o,
	output reg rd_o,
	input wire [7:0] rdata_i
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	task xfer(input [7:0] a, input [7:0] d, input w, output [7:0] q);
		begin
			addr_o <= a;
			wdata_o <= d;
			wr_o <= w;
			rd_o <= !w;
			@(posedge clk_i);
			wr_o <= 1'b0;
			rd_o <= 1'b0;
			// Idle bus shows no stale address or data
			addr_o <= ~a;
			wdata_o <= ~d;
			@(posedge clk_i);
			q = rdata_i;
		end
	endtask
endmodule

// [test/tb_top.sv]
// Self-checking bench for the monitor config/status bank
`timescale 1ns/100ps
module tb_top;
	reg clk_i = 1'b0;
	reg sys_rst_i = 1'b1;
	reg [6:0] limit_fault_i = 7'h00;
	reg [7:0] status_two_i = 8'h00;
	reg [7:0] link_temp_i = 8'h00;
	reg link_temp_valid_i = 1'b0;
	reg [7:0] failsafe_hyst_i = 8'h04;
	reg overtemp_pin_i = 1'b0;
	reg [2:0] overtemp_mode_i = 3'h0;
	reg [7:0] computed_duty_i = 8'h00;
	reg [7:0] max_duty_i = 8'h5c;
	wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pwm_duty_o;
	wire reg_wr_i, reg_rd_i, monitor_run_o, use_default_limits_o;
	wire cpu_link_monitor_enable_o, alert_req_o, failsafe_active_o;
	wire [5:0] average_count_o;
	reg [7:0] q;
	reg [31:0] seed = 32'd99128;
	integer n_mismatch = 0;
	integer total_checks = 0;
	integer cyc = 0;
	integer i;
	// Identity values are arbitrary
	mcsr_regs #(.FAMILY_VERSION(4'h9), .SILICON_REV(2'h1), .MAKER_CODE(8'h33)) dut (.*);
	mcsr_host host (.clk_i(clk_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
		.wr_o(reg_wr_i), .rd_o(reg_rd_i), .rdata_i(reg_rdata_o));
	always #5 clk_i = ~clk_i;
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task tk(input integer n);
		repeat (n) @(posedge clk_i);
	endtask
	task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("wrong value %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		host.xfer(a, d, 1'b1, q);
	endtask
	task rc(input [7:0] a, input [7:0] e, input [63:0] nm);
		begin
			host.xfer(a, 8'h00, 1'b0, q);
			chk(nm, e, q);
		end
	endtask
	task fst(input [7:0] t, input e);
		begin
			link_temp_i <= t;
			link_temp_valid_i <= 1'b1;
			tk(1);
			link_temp_valid_i <= 1'b0;
			tk(2);
			chk("fs", {7'h00, e}, {7'h00, failsafe_active_o});
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", total_checks, n_mismatch);
			if (n_mismatch == 0 && total_checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch = n_mismatch + 1;
			print_verdict;
		end
	end
	initial begin
		tk(10);
		sys_rst_i <= 1'b0;
		tk(20);
		rc(8'h40, 8'h84, "cfg");
		rc(8'h3d, 8'h00, "fslim");
		rc(8'h3e, 8'h33, "maker");
		wr(8'h3f, 8'h00);
		rc(8'h3f, 8'h9d, "version");
		rc(8'h50, 8'h00, "unmapped");
		$display("identity test done");
		for (i = 0; i < 4; i = i + 1) begin
			seed = xs(seed);
			computed_duty_i <= seed[7:0];
			wr(8'h40, {i[1:0], 6'h01});
			tk(2);
			chk("avg", 8'd4 << i, {2'b00, average_count_o});
			chk("pwm", computed_duty_i, pwm_duty_o);
		end
		wr(8'h40, 8'h09);
		tk(2);
		chk("boost", 8'hff, pwm_duty_o);
		wr(8'h40, 8'h01);
		tk(2);
		chk("unboost", computed_duty_i, pwm_duty_o);
		wr(8'h3d, 8'h40);
		fst(8'h41, 1'b1);
		chk("fspwm", 8'hff, pwm_duty_o);
		fst(8'h3d, 1'b1);
		fst(8'h3b, 1'b0);
		wr(8'h3d, 8'h80);
		fst(8'h90, 1'b0);
		$display("duty test done");
		seed = xs(seed);
		limit_fault_i <= seed[6:0] | 7'h01;
		status_two_i <= seed[15:8];
		tk(2);
		chk("alert", 8'h01, {7'h00, alert_req_o});
		limit_fault_i <= seed[6:0] & 7'h55;
		tk(1);
		rc(8'h41, {|seed[15:8], seed[6:0] | 7'h01}, "stat1");
		rc(8'h41, {|seed[15:8], seed[6:0] & 7'h55}, "stat1b");
		limit_fault_i <= 7'h00;
		status_two_i <= 8'h00;
		rc(8'h41, {1'b0, seed[6:0] & 7'h55}, "stat1c");
		rc(8'h41, 8'h00, "stat1d");
		wr(8'h40, 8'h21);
		overtemp_pin_i <= 1'b1;
		tk(5);
		chk("pinfull", 8'hff, pwm_duty_o);
		overtemp_mode_i <= 3'h2;
		tk(2);
		chk("pinmax", 8'h5c, pwm_duty_o);
		overtemp_pin_i <= 1'b0;
		$display("status test done");
		wr(8'h40, 8'h13);
		wr(8'h40, 8'h08);
		tk(2);
		chk("link", 8'h01, {7'h00, cpu_link_monitor_enable_o});
		chk("stopped", 8'hff, pwm_duty_o);
		rc(8'h40, 8'h1e, "cfglock");
		wr(8'h3d, 8'h11);
		rc(8'h3d, 8'h80, "fskept");
		wr(8'h40, 8'h01);
		tk(2);
		chk("rerun", computed_duty_i, pwm_duty_o);
		sys_rst_i <= 1'b1;
		tk(3);
		sys_rst_i <= 1'b0;
		tk(20);
		rc(8'h40, 8'h84, "cfgrst");
		wr(8'h3d, 8'h22);
		rc(8'h3d, 8'h22, "fsnew");
		$display("lock test done");
		print_verdict;
	end
endmodule
